/* File: core/dres_pkg.sv */
// constants and types for the disk error recovery sequencer
package dres_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int CODE_W = 8;
   localparam int RCNT_W = 5;

   // control byte: retry enable bit
   localparam int CTRL_RETRY_BIT = 7;

   ////////////////////////////////////////////////////////////////////////////
   // retry limits
   localparam logic [0:0]        DATA_REREAD_MAX = 1'h1;
   localparam logic [1:0]        DATA_SEQ_MAX    = 2'h3;
   localparam logic [2:0]        SEEK_SEQ_MAX    = 3'h4;
   localparam logic [RCNT_W-1:0] RETRY_MAX       = 5'h14;

   ////////////////////////////////////////////////////////////////////////////
   // status codes
   localparam logic [CODE_W-1:0] C_OK          = 8'h00;
   localparam logic [CODE_W-1:0] C_NO_INDEX    = 8'h01;
   localparam logic [CODE_W-1:0] C_NO_SEEK_CMP = 8'h02;
   localparam logic [CODE_W-1:0] C_WR_FAULT    = 8'h03;
   localparam logic [CODE_W-1:0] C_NOT_READY   = 8'h04;
   localparam logic [CODE_W-1:0] C_NO_TRK0     = 8'h06;
   localparam logic [CODE_W-1:0] C_SEEKING     = 8'h08;
   localparam logic [CODE_W-1:0] C_ID_ERR      = 8'h10;
   localparam logic [CODE_W-1:0] C_UNCORR      = 8'h11;
   localparam logic [CODE_W-1:0] C_NO_MARK     = 8'h12;
   localparam logic [CODE_W-1:0] C_NO_SECTOR   = 8'h14;
   localparam logic [CODE_W-1:0] C_SEEK_ERR    = 8'h15;
   localparam logic [CODE_W-1:0] C_CORR        = 8'h18;
   localparam logic [CODE_W-1:0] C_BAD_TRACK   = 8'h19;
   localparam logic [CODE_W-1:0] C_FORMAT      = 8'h1A;
   localparam logic [CODE_W-1:0] C_ALT_USED    = 8'h1D;
   localparam logic [CODE_W-1:0] C_ALT_NOFMT   = 8'h1E;
   localparam logic [CODE_W-1:0] C_ALT_SAME    = 8'h1F;
   localparam logic [CODE_W-1:0] C_BAD_CMD     = 8'h20;
   localparam logic [CODE_W-1:0] C_BAD_ADDR    = 8'h21;
   localparam logic [CODE_W-1:0] C_RAM_FAIL    = 8'h30;
   localparam logic [CODE_W-1:0] C_CHKSUM      = 8'h31;
   localparam logic [CODE_W-1:0] C_ECC_FAIL    = 8'h32;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      CLS_NONE   = 2'b00,
      CLS_DIRECT = 2'b01,
      CLS_DATA   = 2'b10,
      CLS_SEEK   = 2'b11
   } dres_class_type;

   typedef enum logic [1:0] {
      ACT_REREAD            = 2'b00,
      ACT_RECAL_SEEK_REREAD = 2'b01,
      ACT_RECAL_RESEEK      = 2'b10
   } dres_act_type;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } dres_state_type;

endpackage : dres_pkg

/* File: core/dres_classify.sv */
// sorts a status code into its recovery class
`timescale 1ns/1ns
module dres_classify
   import dres_pkg::*;
(
   // code in
   input  wire logic [CODE_W-1:0] code_i,
   // class out
   output dres_class_type         cls_o
);

   always_comb begin
      case (code_i)
         C_OK: begin
            cls_o = CLS_NONE;
         end
         C_ID_ERR, C_UNCORR, C_NO_MARK, C_NO_SECTOR, C_CORR: begin
            cls_o = CLS_DATA;
         end
         C_SEEK_ERR: begin
            cls_o = CLS_SEEK;
         end
         // drive and host codes go straight out
         C_NO_INDEX, C_NO_SEEK_CMP, C_WR_FAULT, C_NOT_READY, C_NO_TRK0, C_SEEKING,
         C_BAD_TRACK, C_FORMAT, C_ALT_USED, C_ALT_NOFMT, C_ALT_SAME, C_BAD_CMD,
         C_BAD_ADDR, C_RAM_FAIL, C_CHKSUM, C_ECC_FAIL: begin
            cls_o = CLS_DIRECT;
         end
         // unknown codes are reported unchanged as well
         default: begin
            cls_o = CLS_DIRECT;
         end
      endcase
   end

endmodule : dres_classify

/* File: core/dres_sequencer.sv */
// disk error recovery sequencer: retry decisions and final status code
`timescale 1ns/1ns
//
// What this block does
// - retries only when control byte bit 7 set
// - drive faults reported as 01..08 codes
// - bad track, format, command, address codes reported
// - alternate track faults reported as 1D/1E/1F
// - self-test faults reported as 30/31/32
// - codes 10,11,12,14,18 are data errors
// - data error: one reread, three recal-seek-rereads
// - seek error: up to four recal-reseek cycles
// - at most twenty retries per command
module dres_sequencer
   import dres_pkg::*;
(
   // clock and reset
   input  wire logic              CLK_SYS_I,
   input  wire logic              SYS_RST_I,
   // command from host side
   input  wire logic              CMD_START_I,
   input  wire logic [7:0]        CMD_CTRL_BYTE_I,
   // result of each drive operation
   input  wire logic              OP_DONE_I,
   input  wire logic [CODE_W-1:0] OP_CODE_I,
   // retry request to drive side
   output logic                   ACT_REQ_O,
   output dres_act_type           ACT_KIND_O,
   // command completion
   output logic                   CMD_END_O,
   output logic [CODE_W-1:0]      CMD_STATUS_O,
   output logic                   BUSY_O,
   output logic [RCNT_W-1:0]      RETRY_CNT_O
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   dres_state_type    state_q;
   logic              enable_q;
   logic [0:0]        reread_q;
   logic [1:0]        data_seq_q;
   logic [2:0]        seek_seq_q;
   logic [RCNT_W-1:0] retry_q;
   dres_class_type    op_cls;
   logic              op_take;
   logic              do_retry;
   dres_act_type      act_kind_d;

   assign op_take = (state_q == ST_WAIT) && OP_DONE_I;

   ////////////////////////////////////////////////////////////////////////////
   // code classification
   dres_classify u_classify (
      .code_i (OP_CODE_I),
      .cls_o  (op_cls)
   );

   ////////////////////////////////////////////////////////////////////////////
   // retry decision
   always_comb begin
      do_retry   = 1'b0;
      act_kind_d = ACT_REREAD;
      if (enable_q && (retry_q < RETRY_MAX)) begin
         case (op_cls)
            CLS_DATA: begin
               if (reread_q < DATA_REREAD_MAX) begin
                  do_retry   = 1'b1;
                  act_kind_d = ACT_REREAD;
               end else if (data_seq_q < DATA_SEQ_MAX) begin
                  do_retry   = 1'b1;
                  act_kind_d = ACT_RECAL_SEEK_REREAD;
               end
            end
            CLS_SEEK: begin
               if (seek_seq_q < SEEK_SEQ_MAX) begin
                  do_retry   = 1'b1;
                  act_kind_d = ACT_RECAL_RESEEK;
               end
            end
            default: begin
               do_retry = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command state
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state_q  <= ST_IDLE;
         enable_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (CMD_START_I) begin
                  state_q  <= ST_WAIT;
                  enable_q <= CMD_CTRL_BYTE_I[CTRL_RETRY_BIT];
               end
            end
            ST_WAIT: begin
               if (OP_DONE_I && !do_retry) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // retry counters
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         reread_q   <= 1'h0;
         data_seq_q <= 2'h0;
         seek_seq_q <= 3'h0;
         retry_q    <= 5'h00;
      end else if ((state_q == ST_IDLE) && CMD_START_I) begin
         reread_q   <= 1'h0;
         data_seq_q <= 2'h0;
         seek_seq_q <= 3'h0;
         retry_q    <= 5'h00;
      end else if (op_take && do_retry) begin
         retry_q <= retry_q + 5'h01;
         case (act_kind_d)
            ACT_REREAD: begin
               reread_q <= reread_q + 1'h1;
            end
            ACT_RECAL_SEEK_REREAD: begin
               data_seq_q <= data_seq_q + 2'h1;
            end
            ACT_RECAL_RESEEK: begin
               seek_seq_q <= seek_seq_q + 3'h1;
            end
            default: begin
               retry_q <= retry_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // retry request outputs
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         ACT_REQ_O  <= 1'b0;
         ACT_KIND_O <= ACT_REREAD;
      end else begin
         ACT_REQ_O <= op_take && do_retry;
         if (op_take && do_retry) begin
            ACT_KIND_O <= act_kind_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // completion outputs
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         CMD_END_O    <= 1'b0;
         CMD_STATUS_O <= C_OK;
      end else begin
         CMD_END_O <= op_take && !do_retry;
         if (op_take && !do_retry) begin
            CMD_STATUS_O <= OP_CODE_I;
         end
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         BUSY_O      <= 1'b0;
         RETRY_CNT_O <= 5'h00;
      end else begin
         BUSY_O      <= ((state_q == ST_IDLE) && CMD_START_I) || (op_take && do_retry) ||
                        ((state_q == ST_WAIT) && !OP_DONE_I);
         RETRY_CNT_O <= ((state_q == ST_IDLE) && CMD_START_I) ? 5'h00 :
                        (op_take && do_retry) ? retry_q + 5'h01 : retry_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_retry_needs_enable;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      op_take && !enable_q && (op_cls != CLS_NONE) |=> CMD_END_O && !ACT_REQ_O;
   endproperty
   a_retry_needs_enable: assert property (p_retry_needs_enable)
      else $error("retry issued while recovery disabled");

   property p_drive_fault;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      op_take && (OP_CODE_I == C_NOT_READY || OP_CODE_I == C_SEEKING)
      |=> CMD_END_O && (CMD_STATUS_O == $past(OP_CODE_I));
   endproperty
   a_drive_fault: assert property (p_drive_fault)
      else $error("drive fault not reported directly");

   property p_host_fault;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      op_take && (OP_CODE_I == C_BAD_CMD || OP_CODE_I == C_BAD_ADDR)
      |=> CMD_END_O ##1 !CMD_END_O;
   endproperty
   a_host_fault: assert property (p_host_fault)
      else $error("host fault not ended in one pulse");

   property p_alt_fault;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      op_take && (OP_CODE_I == C_ALT_SAME) |=> (CMD_STATUS_O == C_ALT_SAME) && !BUSY_O;
   endproperty
   a_alt_fault: assert property (p_alt_fault)
      else $error("alternate track fault wrong status");

   property p_selftest;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      op_take && (OP_CODE_I == C_RAM_FAIL) |=> !ACT_REQ_O && (CMD_STATUS_O == C_RAM_FAIL);
   endproperty
   a_selftest: assert property (p_selftest)
      else $error("self-test fault retried or misreported");

   property p_data_first_reread;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      op_take && enable_q && (OP_CODE_I == C_CORR) && (retry_q == 5'h00)
      |=> ACT_REQ_O && (ACT_KIND_O == ACT_REREAD);
   endproperty
   a_data_first_reread: assert property (p_data_first_reread)
      else $error("data error did not start with reread");

   property p_data_seq_limit;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      ACT_REQ_O && (ACT_KIND_O == ACT_RECAL_SEEK_REREAD)
      |-> (reread_q == DATA_REREAD_MAX) && (data_seq_q != 2'h0);
   endproperty
   a_data_seq_limit: assert property (p_data_seq_limit)
      else $error("data sequence out of order");

   property p_seek_limit;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      op_take && (op_cls == CLS_SEEK) && (seek_seq_q == SEEK_SEQ_MAX) |=> !ACT_REQ_O;
   endproperty
   a_seek_limit: assert property (p_seek_limit)
      else $error("more than four seek retries");

   property p_retry_cap;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      op_take && (retry_q == RETRY_MAX) |=> CMD_END_O && (RETRY_CNT_O == RETRY_MAX);
   endproperty
   a_retry_cap: assert property (p_retry_cap)
      else $error("retry cap exceeded");

   property p_retry_step;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      ACT_REQ_O |-> (RETRY_CNT_O == retry_q) && (retry_q != 5'h00) && (retry_q <= RETRY_MAX);
   endproperty
   a_retry_step: assert property (p_retry_step)
      else $error("retry count not advanced with action");

   property p_ok_status;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      op_take && (OP_CODE_I == C_OK) |=> CMD_END_O && (CMD_STATUS_O == C_OK);
   endproperty
   a_ok_status: assert property (p_ok_status)
      else $error("success not reported as 00");

   property p_direct_no_retry;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      op_take && (op_cls == CLS_DIRECT) |=> !ACT_REQ_O && $fell(BUSY_O);
   endproperty
   a_direct_no_retry: assert property (p_direct_no_retry)
      else $error("direct class error was retried");

endmodule : dres_sequencer

/* File: test/dres_drive_model.sv */
// drive-side responder: answers every attempt with the next scripted result code, or 00 once the script is empty
`timescale 1ns/1ns
module dres_drive_model
   import dres_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // attempt triggers from sequencer
   input  wire logic              busy_i,
   input  wire logic              act_req_i,
   input  wire logic [2:0]        delay_i,
   // result back to sequencer
   output logic                   done_o,
   output logic [CODE_W-1:0]      code_o
);
   logic [CODE_W-1:0] script_q[$];
   logic [CODE_W-1:0] last_q;
   logic [CODE_W-1:0] nxt;
   logic              busy_q;
   int                wait_q;

   task automatic load(input logic [CODE_W-1:0] c);
      script_q.push_back(c);
   endtask : load

   ////////////////////////////////////////////////////////////////////////////
   // code line shows inverse of last value outside a result
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
         done_o <= 1'b0;
         code_o <= 8'h00;
         last_q <= 8'h00;
         wait_q <= -1;
      end else begin
         busy_q <= busy_i;
         done_o <= 1'b0;
         code_o <= ~last_q;
         if ((busy_i && !busy_q) || act_req_i) begin
            wait_q <= delay_i;
         end else if (wait_q == 0) begin
            nxt = (script_q.size() > 0) ? script_q.pop_front() : C_OK;
            done_o <= 1'b1;
            code_o <= nxt;
            last_q <= nxt;
            wait_q <= -1;
         end else if (wait_q > 0) begin
            wait_q <= wait_q - 1;
         end
      end
   end
endmodule : dres_drive_model

/* File: test/tb.sv */
// self-checking bench for the disk error recovery sequencer
`timescale 1ns/1ns
module tb
   import dres_pkg::*;
;
   logic              clk, rst, start, done;
   logic              done_d = 1'b0;
   logic [7:0]        ctrl;
   logic [CODE_W-1:0] opc, status;
   logic [2:0]        dly;
   logic              act_req, cmd_end, busy;
   dres_act_type      act_kind;
   logic [RCNT_W-1:0] rcnt;
   logic [15:0]       lfsr_q = 16'h0008;
   logic [7:0]        seq_q[$];
   dres_act_type      exp_kind[$];
   int                fails = 0;
   int                checks = 0;
   // 0 ok, 1..17 direct (17 unknown), 18..22 data, 23 seek
   logic [7:0] tab [24] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h19,
      8'h1A, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h30, 8'h31, 8'h32, 8'h7E,
      8'h10, 8'h11, 8'h12, 8'h14, 8'h18, 8'h15};

   dres_sequencer uut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .CMD_START_I(start),
      .CMD_CTRL_BYTE_I(ctrl), .OP_DONE_I(done), .OP_CODE_I(opc), .ACT_REQ_O(act_req),
      .ACT_KIND_O(act_kind), .CMD_END_O(cmd_end), .CMD_STATUS_O(status), .BUSY_O(busy),
      .RETRY_CNT_O(rcnt));
   dres_drive_model drv (.clk_i(clk), .rst_i(rst), .busy_i(busy), .act_req_i(act_req),
      .delay_i(dly), .done_o(done), .code_o(opc));

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   task automatic miss(input logic [7:0] g, input logic [7:0] e);
      fails++;
      $display("Error at %0t got %h expected %h", $time, g, e);
   endtask : miss

   task automatic cmp_code(input logic [CODE_W-1:0] g, input logic [CODE_W-1:0] e);
      checks++;
      if (g !== e) miss(g, e);
   endtask : cmp_code

   task automatic cmp_cnt(input logic [RCNT_W-1:0] g, input logic [RCNT_W-1:0] e);
      checks++;
      if (g !== e) miss(8'(g), 8'(e));
   endtask : cmp_cnt

   task automatic cmp_kind(input dres_act_type g, input dres_act_type e);
      checks++;
      if (g !== e) miss(8'(g), 8'(e));
   endtask : cmp_kind

   task automatic cmp_flag(input logic g, input logic e);
      checks++;
      if (g !== e) miss(8'(g), 8'(e));
   endtask : cmp_flag

   function automatic logic [15:0] lfsr();
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      return lfsr_q;
   endfunction : lfsr

   // next retry action for a result, -1 when the command ends
   function automatic int predict(input logic [7:0] cd, input logic en,
                                  inout int rr, inout int ds, inout int sk, inout int n);
      bit dat;
      dat = (cd == 8'h10) || (cd == 8'h11) || (cd == 8'h12) || (cd == 8'h14) ||
            (cd == 8'h18);
      predict = -1;
      if (cd == 8'h00 || !en || n >= 20) return -1;
      if (dat && rr < 1) begin
         rr++;
         predict = 0;
      end else if (dat && ds < 3) begin
         ds++;
         predict = 1;
      end else if (cd == 8'h15 && sk < 4) begin
         sk++;
         predict = 2;
      end
      if (predict >= 0) n++;
   endfunction : predict

   ////////////////////////////////////////////////////////////////////////////
   // every result answered next cycle by exactly one of action or end
   always @(posedge clk) begin
      if (done_d) cmp_flag(act_req ^ cmd_end, 1'b1);
      if (act_req === 1'b1 && exp_kind.size() == 0) miss(8'(act_kind), 8'hFF);
      else if (act_req === 1'b1) cmp_kind(act_kind, exp_kind.pop_front());
      done_d = done & busy;
   end

   task automatic run_cmd(input logic [7:0] c, input bit poke);
      int rr, ds, sk, n, a, t;
      logic [7:0] st;
      rr = 0;
      ds = 0;
      sk = 0;
      n = 0;
      st = 8'h00;
      foreach (seq_q[i]) begin
         drv.load(seq_q[i]);
         a = predict(seq_q[i], c[7], rr, ds, sk, n);
         if (a < 0) begin
            st = seq_q[i];
            break;
         end
         exp_kind.push_back(dres_act_type'(a));
      end
      @(posedge clk);
      #1 start = 1'b1;
      ctrl = c;
      @(posedge clk);
      #1 start = 1'b0;
      if (poke) begin
         @(posedge clk);
         #1 start = 1'b1;
         ctrl = 8'h00;
         @(posedge clk);
         #1 start = 1'b0;
      end
      for (t = 0; t < 300; t++) begin
         if (cmd_end === 1'b1) break;
         @(posedge clk);
         #1 dly = 3'(lfsr() % 4);
      end
      if (t == 300) begin
         fails++;
         print_verdict();
      end
      cmp_code(status, st);
      cmp_cnt(rcnt, n[4:0]);
      cmp_flag(busy, 1'b0);
      cmp_cnt(5'(exp_kind.size()), 5'h00);
   endtask : run_cmd

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      start = 1'b0;
      ctrl = 8'h00;
      dly = 3'h0;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      cmp_code(status, 8'h00);
      cmp_flag(busy | act_req | cmd_end, 1'b0);
      cmp_cnt(rcnt, 5'h00);
      for (int i = 1; i < 24; i++) begin
         seq_q = {tab[i], tab[i], tab[i], tab[i], tab[i], tab[i]};
         run_cmd(8'h80, i[0]);
         run_cmd(8'h7F, 1'b0);
      end
      seq_q = {8'h15, 8'h11, 8'h15, 8'h18, 8'h15, 8'h10, 8'h15, 8'h12, 8'h15, 8'h14};
      run_cmd(8'hFF, 1'b1);
      seq_q = {8'h11, 8'h00};
      run_cmd(8'h80, 1'b0);
      repeat (60) begin
         seq_q = {};
         repeat (1 + lfsr() % 8) seq_q.push_back(tab[lfsr() % 24]);
         run_cmd(8'(lfsr()), 1'b0);
      end
      print_verdict();
   end
endmodule : tb
